// >>> verilog/pnb_pkg.sv
/*
  Constants, types and reset values shared by the byte-wide boot loader
  port and its address counter.
  Assumes a single 250 MHz clock domain and an active-low async reset.
*/
package pnb_pkg;
  // Address and data widths of the flash side.
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  // Start addresses for the two directions.
  localparam logic [ADDR_W-1:0] ADDR_UP_START = 24'h000000;
  localparam logic [ADDR_W-1:0] ADDR_DN_START = 24'hffffff;
  // Mode code that selects this loader, upper two bits.
  localparam logic [1:0] MODE_UPPER = 2'h1;
  // Config clock half period in system clocks (cfg clock 31.25 MHz).
  localparam int CFG_CLK_OUT_HALF = 4;
  // Initialization (memory clearing) duration in system clocks.
  localparam int INIT_CYCLES = 64;
  // Reset values of the loader state.
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  localparam logic [7:0] CKSUM_RESET = 8'h00;

  // Loader states.
  typedef enum logic [2:0] {
    PNB_IDLE = 3'b000,
    PNB_INIT = 3'b001,
    PNB_LOAD = 3'b010,
    PNB_DONE = 3'b011,
    PNB_FAIL = 3'b100
  } pnb_state_t;
endpackage

// >>> verilog/pnb_addr_if.sv
/*
  Interface between the loader control and its address counter.
  Assumes both ends share the same clock and reset.
*/
interface pnb_addr_if;
  import pnb_pkg::*;
  logic load;                 // Preset the counter to the start address.
  logic down;                 // Count downward when set.
  logic step;                 // Advance by one this cycle.
  logic [ADDR_W-1:0] addr;    // Current address presented to the flash.
  modport ctl (output load, output down, output step, input addr);
  modport cnt (input load, input down, input step, output addr);
endinterface

// >>> verilog/pnb_addr_cnt.sv
/*
  Up/down address counter for the boot loader.
  Assumes the controller pulses step on each falling config clock edge.
*/
module pnb_addr_cnt
  import pnb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  pnb_addr_if.cnt ai
);
  // Preset on load, otherwise step by one in the chosen direction.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ai.addr <= ADDR_RESET;
    end else if (ai.load) begin
      ai.addr <= ai.down ? ADDR_DN_START : ADDR_UP_START;
    end else if (ai.step) begin
      // Wraps silently at the ends; a real image never gets that far.
      ai.addr <= ai.down ? ai.addr - 24'h000001
                         : ai.addr + 24'h000001;
    end
  end
endmodule

// >>> verilog/pnb_loader.sv
/*
  Byte-wide parallel flash boot loader port: presents addresses, reads
  bytes, checks a running checksum and hands pins to user logic after.
  Assumes an asynchronous NOR flash and pins synchronised here.
*/
module pnb_loader
  import pnb_pkg::*;
#(
  parameter int IMAGE_BYTES = 1024 // Bytes in the image, checksum last.
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cfg_restart_n,
  input wire logic [2:0] mode_sel,
  input wire logic pullup_disable_ctl,
  input wire logic chip_select_n,
  input wire logic port_write_n,
  input wire logic [pnb_pkg::DATA_W-1:0] mem_data_in,
  input wire logic retain_port,
  input wire logic user_chip_enable_n,
  input wire logic user_width_select,
  output logic [pnb_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_chip_enable_n,
  output logic mem_output_enable_n,
  output logic mem_write_enable_n,
  output logic mem_width_select,
  output logic downstream_select_n,
  output logic cfg_clk_out,
  output logic busy,
  output logic init_out,
  output logic init_oe,
  input wire logic init_in,
  output logic done_out,
  output logic done_oe,
  output logic pullups_enabled,
  output logic slave_port_active,
  output logic port_write_active,
  output logic [pnb_pkg::DATA_W-1:0] cfg_data,
  output logic cfg_data_valid,
  output logic user_pins
);
  import pnb_pkg::*;

  // Two-stage synchronisers for the sampled pins; restart passes four stages and the user-side inputs none.
  logic [1:0] rst_s1_r, rst_s2_r;
  logic [2:0] mode_s1_r, mode_s2_r;
  logic hsw_s1_r, hsw_s2_r, cs_s1_r, cs_s2_r, wr_s1_r, wr_s2_r;
  logic init_s1_r, init_s2_r, init_d_r;
  logic [DATA_W-1:0] dat_s1_r, dat_s2_r;

  pnb_state_t state_r, state_nxt;    // Loader state.
  logic [2:0] mode_r;                // Mode caught at init release.
  logic pullup_dis_r;                // Pull-up control caught at start.
  logic [7:0] half_r;                // Config clock half-period count.
  logic cfg_clk_out_r;                      // Config clock level.
  logic [15:0] cnt_r;                // Init wait / byte counter.
  logic [7:0] sum_r;                 // Running checksum of the image.
  logic restart_seen_r;              // Restart low seen, awaiting release.
  logic fall;                        // Config clock falls this cycle.
  logic init_rise;                   // Init indicator line rose.

  pnb_addr_if ai ();

  pnb_addr_cnt u_cnt (
    .clk(clk),
    .resetn(resetn),
    .ai(ai)
  );

  // Synchronise the pins; logic reads the last stage of each, plus init_d_r for the init edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 2'h3;
      rst_s2_r <= 2'h3;
      mode_s1_r <= 3'h0;
      mode_s2_r <= 3'h0;
      hsw_s1_r <= 1'b0;
      hsw_s2_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      wr_s1_r <= 1'b1;
      wr_s2_r <= 1'b1;
      init_s1_r <= 1'b0;
      init_s2_r <= 1'b0;
      init_d_r <= 1'b0;
      dat_s1_r <= 8'h00;
      dat_s2_r <= 8'h00;
    end else begin
      rst_s1_r <= {rst_s1_r[0], cfg_restart_n};
      rst_s2_r <= {rst_s2_r[0], rst_s1_r[1]};
      mode_s1_r <= mode_sel;
      mode_s2_r <= mode_s1_r;
      hsw_s1_r <= pullup_disable_ctl;
      hsw_s2_r <= hsw_s1_r;
      cs_s1_r <= chip_select_n;
      cs_s2_r <= cs_s1_r;
      wr_s1_r <= port_write_n;
      wr_s2_r <= wr_s1_r;
      init_s1_r <= init_in;
      init_s2_r <= init_s1_r;
      init_d_r <= init_s2_r;
      dat_s1_r <= mem_data_in;
      dat_s2_r <= dat_s1_r;
    end
  end

  assign init_rise = init_s2_r & ~init_d_r;

  // Restart is acted on when the pin returns high after being low.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      restart_seen_r <= 1'b0;
    end else if (!rst_s2_r[1]) begin
      restart_seen_r <= 1'b1;
    end else if (state_r == PNB_INIT) begin
      restart_seen_r <= 1'b0;
    end
  end

  // Free-running config clock divider; it stays driven in every state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      half_r <= 8'h00;
      cfg_clk_out_r <= 1'b1;
    end else if (half_r == 8'(CFG_CLK_OUT_HALF - 1)) begin
      half_r <= 8'h00;
      cfg_clk_out_r <= ~cfg_clk_out_r;
    end else begin
      half_r <= half_r + 8'h01;
    end
  end

  assign fall = cfg_clk_out_r && (half_r == 8'(CFG_CLK_OUT_HALF - 1));

  // Next state of the loader.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PNB_IDLE: begin
        if (rst_s2_r[1]) state_nxt = PNB_INIT;
      end
      PNB_INIT: begin
        // Wait for memory clearing and the released indicator to rise.
        if (init_rise && cnt_r >= 16'(INIT_CYCLES)) begin
          // Only the documented upper mode code starts a load.
          if (mode_s2_r[2:1] == MODE_UPPER) state_nxt = PNB_LOAD;
          else state_nxt = PNB_FAIL;
        end
      end
      PNB_LOAD: begin
        // Outside select and write control must stay low.
        if (cs_s2_r || wr_s2_r) state_nxt = PNB_FAIL;
        else if (fall && cnt_r == 16'(IMAGE_BYTES - 1)) begin
          if (sum_r + dat_s2_r == CKSUM_RESET) state_nxt = PNB_DONE;
          else state_nxt = PNB_FAIL;
        end
      end
      PNB_DONE: state_nxt = PNB_DONE;
      PNB_FAIL: state_nxt = PNB_FAIL;
      default: state_nxt = PNB_IDLE;
    endcase
    if (restart_seen_r && rst_s2_r[1] && state_r != PNB_INIT)
      state_nxt = PNB_INIT;
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) state_r <= PNB_IDLE;
    else state_r <= state_nxt;
  end

  // Init wait counter, then byte counter during the load.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 16'h0000;
    end else if (state_nxt != state_r) begin
      cnt_r <= 16'h0000;
    end else if (state_r == PNB_INIT && cnt_r < 16'(INIT_CYCLES)) begin
      cnt_r <= cnt_r + 16'h0001;
    end else if (state_r == PNB_LOAD && fall) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Mode bits and pull-up control are caught as init is released.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= 3'h0;
      pullup_dis_r <= 1'b0;
    end else if (state_r == PNB_INIT && init_rise) begin
      mode_r <= mode_s2_r;
      pullup_dis_r <= hsw_s2_r;
    end
  end

  // Address counter control: preset throughout init, step on falling edges.
  assign ai.load = (state_r == PNB_INIT);
  assign ai.down = (state_r == PNB_INIT) ? mode_s2_r[0] : mode_r[0];
  assign ai.step = (state_r == PNB_LOAD) && fall;

  // Each byte is sampled just before the address moves on.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sum_r <= CKSUM_RESET;
      cfg_data <= 8'h00;
      cfg_data_valid <= 1'b0;
    end else begin
      cfg_data_valid <= ai.step;
      if (state_r == PNB_INIT) begin
        sum_r <= CKSUM_RESET;
      end else if (ai.step) begin
        cfg_data <= dat_s2_r;
        sum_r <= sum_r + dat_s2_r;
      end
    end
  end

  // Address presented from the counter register.
  assign mem_addr = ai.addr;

  // Flash strobes are fixed during load; afterwards user logic drives chip enable and width select only.
  always_comb begin
    user_pins = (state_r == PNB_DONE);
    if (user_pins) begin
      mem_chip_enable_n = user_chip_enable_n;
      mem_width_select = user_width_select;
    end else begin
      mem_chip_enable_n = 1'b0;
      mem_width_select = 1'b0;
    end
    mem_output_enable_n = 1'b0;
    mem_write_enable_n = 1'b1;
  end

  // Single device: these stay actively driven though unused.
  assign downstream_select_n = 1'b1;
  assign cfg_clk_out = cfg_clk_out_r;
  assign busy = 1'b0;

  // Open-drain indicators: init is driven low while clearing or after an error, done until the load completes.
  assign init_out = 1'b0;
  assign init_oe = (state_r == PNB_IDLE) ||
                   (state_r == PNB_INIT && cnt_r < 16'(INIT_CYCLES)) ||
                   (state_r == PNB_FAIL);
  assign done_out = 1'b0;
  assign done_oe = (state_r != PNB_DONE);

  assign pullups_enabled = !pullup_dis_r && !user_pins;
  // Slave port survives only with the retain option set.
  assign slave_port_active = user_pins && retain_port;
  assign port_write_active = slave_port_active && !wr_s2_r;
endmodule

// >>> dv/pnb_flash_model.sv
/*
  Byte-wide NOR flash model holding an eight byte image.
  Assumes the loader drives address and strobes; writes are ignored.
*/
module pnb_flash_model
  import pnb_pkg::*;
(
  input wire logic [pnb_pkg::ADDR_W-1:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic corrupt,
  output logic [pnb_pkg::DATA_W-1:0] data
);
  logic [DATA_W-1:0] last = 8'h00; // Last byte driven, for the idle bus.
  // Image bytes add to zero modulo 256; corrupt spoils every byte.
  always @* begin
    if (!ce_n && !oe_n) begin
      data = (addr[2:0] == 3'h7) ? 8'h24 : 8'(8'h11 * (addr[2:0] + 1));
      data = data ^ {DATA_W{corrupt}};
      last = data;
    end else begin
      // A released bus must not look like the last value.
      data = ~last;
    end
  end
endmodule

// >>> dv/pnb_loader_asserts.sv
/*
  Checker for the boot loader port, watching top-level ports only.
  Assumes one clock and the async active-low reset.
*/
module pnb_loader_asserts
  import pnb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] mode_sel,
  input wire logic pullup_disable_ctl,
  input wire logic chip_select_n,
  input wire logic retain_port,
  input wire logic user_chip_enable_n,
  input wire logic [pnb_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_chip_enable_n,
  input wire logic mem_output_enable_n,
  input wire logic mem_write_enable_n,
  input wire logic mem_width_select,
  input wire logic downstream_select_n,
  input wire logic cfg_clk_out,
  input wire logic busy,
  input wire logic init_oe,
  input wire logic done_oe,
  input wire logic pullups_enabled,
  input wire logic slave_port_active,
  input wire logic cfg_data_valid,
  input wire logic user_pins
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire loading; // Init released but not yet done.
  assign loading = done_oe && !init_oe;
  sequence s_clk_high4;
    cfg_clk_out [*4];
  endsequence
  a_ce_held: assert property (
    done_oe |-> !mem_chip_enable_n) else $error("chip enable dropped");
  a_strobe_levels: assert property (
    done_oe |-> !mem_output_enable_n && mem_write_enable_n)
    else $error("strobe level wrong");
  a_width_low: assert property (
    done_oe |-> !mem_width_select) else $error("width select high");
  a_unused_driven: assert property (
    done_oe |-> downstream_select_n && !busy) else $error("idle pins wrong");
  a_cfg_clk_out_high: assert property (
    $rose(cfg_clk_out) |-> s_clk_high4) else $error("cfg clock period");
  a_addr_step: assert property (
    $changed(mem_addr) && loading && $past(loading) |->
    mem_addr == $past(mem_addr) + (mode_sel[0] ? 24'hffffff : 24'h000001))
    else $error("address step wrong");
  a_pullup_mode: assert property (
    cfg_data_valid |->
    pullups_enabled == (!pullup_disable_ctl && !user_pins))
    else $error("pull-up control wrong");
  a_cs_refused: assert property (
    loading && chip_select_n |-> ##[1:8] init_oe)
    else $error("select loss not refused");
  a_done_user: assert property (
    !done_oe |-> user_pins && mem_chip_enable_n == user_chip_enable_n)
    else $error("user handover wrong");
  a_retain_port: assert property (
    !done_oe |-> slave_port_active == retain_port)
    else $error("retained port wrong");
endmodule
bind pnb_loader pnb_loader_asserts u_chk (.clk, .resetn, .mode_sel,
  .pullup_disable_ctl, .chip_select_n, .retain_port, .user_chip_enable_n,
  .mem_addr, .mem_chip_enable_n, .mem_output_enable_n, .mem_write_enable_n,
  .mem_width_select, .downstream_select_n, .cfg_clk_out, .busy, .init_oe,
  .done_oe, .pullups_enabled, .slave_port_active, .cfg_data_valid,
  .user_pins);

// >>> dv/test_pnb_loader.sv
/*
  Self-checking bench for the boot loader port with an 8 byte image.
  Assumes the flash model in its own file and a pulled-up init line.
*/
module test_pnb_loader;
  timeunit 1ns;
  timeprecision 1ps;
  import pnb_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, cfg_restart_n = 1'b1, corrupt = 1'b0;
  logic [2:0] mode_sel = 3'h2;
  logic pullup_disable_ctl = 1'b0, chip_select_n = 1'b0, port_write_n = 1'b0;
  logic retain_port = 1'b0, user_chip_enable_n = 1'b0;
  logic user_width_select = 1'b0;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_data_in, cfg_data;
  logic mem_chip_enable_n, mem_output_enable_n, mem_write_enable_n, busy;
  logic mem_width_select, downstream_select_n, cfg_clk_out, init_out;
  logic init_oe, init_in, done_out, done_oe, pullups_enabled, user_pins;
  logic slave_port_active, port_write_active, cfg_data_valid;
  int errors = 0, tests_run = 0;
  always #2 clk = ~clk;
  // Open-drain init line: the pull-up wins when nobody drives.
  assign init_in = init_oe ? init_out : 1'b1;
  pnb_loader #(.IMAGE_BYTES(8)) DUT (.clk, .resetn, .cfg_restart_n,
    .mode_sel, .pullup_disable_ctl, .chip_select_n, .port_write_n,
    .mem_data_in, .retain_port, .user_chip_enable_n, .user_width_select,
    .mem_addr, .mem_chip_enable_n, .mem_output_enable_n,
    .mem_write_enable_n, .mem_width_select, .downstream_select_n,
    .cfg_clk_out, .busy, .init_out, .init_oe, .init_in, .done_out,
    .done_oe, .pullups_enabled, .slave_port_active, .port_write_active,
    .cfg_data, .cfg_data_valid, .user_pins);
  pnb_flash_model u_flash (.addr(mem_addr), .ce_n(mem_chip_enable_n),
    .oe_n(mem_output_enable_n), .corrupt, .data(mem_data_in));
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  // Restart, then follow one load; cut drops the select mid-load.
  task automatic run(input string name, input logic [2:0] mode,
                     input logic bad, input logic cut, input logic ok);
    int n;
    logic [7:0] exp;
    n = 0;
    mode_sel = mode;
    corrupt = bad;
    cfg_restart_n = 1'b0;
    repeat (3) @(negedge clk);
    cfg_restart_n = 1'b1;
    // The release needs four synchroniser stages and one state edge
    // before done is pulled low again; wait so a prior success is not
    // mistaken for this load.
    repeat (8) @(negedge clk);
    for (int i = 0; i < 600 && done_oe !== 1'b0; i++) begin
      @(negedge clk);
      if (cfg_data_valid === 1'b1) begin
        exp = mode[0] ? 8'(8'h11 * (8 - n)) : 8'(8'h11 * (n + 1));
        if (n == (mode[0] ? 0 : 7)) exp = 8'h24;
        if (!bad) check(cfg_data === exp, "byte order");
        // Pull-ups follow the control only until user pins take over.
        check(pullups_enabled === (done_oe & ~pullup_disable_ctl), "pull-up level");
        if (cut && n == 2) chip_select_n = 1'b1;
        n++;
      end
    end
    if (ok) check(done_oe === 1'b0 && n == 8, "load not done");
    if (!ok) check(init_oe === 1'b1 && done_oe === 1'b1, "no refusal");
    chip_select_n = 1'b0;
    $display("Test %s finished", name);
    if (ok && done_oe !== 1'b0) give_verdict();
  endtask
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    run("load up", 3'h2, 1'b0, 1'b0, 1'b1);
    check(slave_port_active === 1'b0, "port kept");
    check(init_out === 1'b0 && done_out === 1'b0, "open drain level");
    retain_port = 1'b1;
    user_chip_enable_n = 1'b1;
    user_width_select = 1'b1;
    port_write_n = 1'b1;
    // The write pin passes two flip-flops before the port sees it.
    repeat (3) @(negedge clk);
    check(mem_chip_enable_n === 1'b1, "no deselect");
    check(mem_width_select === 1'b1, "no x16");
    check(slave_port_active === 1'b1, "port lost");
    check(port_write_active === 1'b0, "write active");
    port_write_n = 1'b0;
    repeat (3) @(negedge clk);
    check(port_write_active === 1'b1, "write missing");
    retain_port = 1'b0;
    user_chip_enable_n = 1'b0;
    user_width_select = 1'b0;
    pullup_disable_ctl = 1'b1;
    run("load down", 3'h3, 1'b0, 1'b0, 1'b1);
    pullup_disable_ctl = 1'b0;
    run("bad sum", 3'h2, 1'b1, 1'b0, 1'b0);
    run("select lost", 3'h2, 1'b0, 1'b1, 1'b0);
    run("bad mode", 3'h6, 1'b0, 1'b0, 1'b0);
    give_verdict();
  end
endmodule
